/* File: rtl/dual_port_bidir_io.v */
// Two 8-bit bidirectional ports with a byte-wide control register port.
// Assumes a CPU-side strobe interface synchronous to clk; pins asynchronous.
//
// Summary of operation
// - Direction bit 1 drives pin, 0 inputs
// - Direction registers reset to 00h, all inputs
// - Direction registers are write-only, not readable
// - Written data appears on output pins
// - Data read returns sampled level on inputs
// - Data registers have no reset value
// - Open-drain bit 1 open drain, 0 push-pull
// - Open-drain registers write-only, reset 00h
// - Pull-up bit 0 enables, 1 disables
// - Output pins never have pull-up
// - First pull-up register write-only, reset 00h
// - Mode bit 0 port, 1 alternate function
// - Mode register write-only, reset 00h
// - Second direction only matters in port mode
// - First port data C0, direction C1
// - Second port data C2, direction C3
`timescale 1ns/1ns
`default_nettype none
`include "dual_port_bidir_io_regs.vh"

module dual_port_bidir_io #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Control register port
  input  wire [7:0]       reg_addr,
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [7:0]       reg_wdata,
  output reg  [7:0]       reg_rdata,
  output reg              reg_hit,
  // First port pins
  input  wire [WIDTH-1:0] first_pin_in,
  output wire [WIDTH-1:0] first_pin_out,
  output wire [WIDTH-1:0] first_pin_oe,
  output wire [WIDTH-1:0] first_pin_pullup_en,
  // Second port pins
  input  wire [WIDTH-1:0] second_pin_in,
  output wire [WIDTH-1:0] second_pin_out,
  output wire [WIDTH-1:0] second_pin_oe,
  output wire [WIDTH-1:0] second_pin_pullup_en,
  // Peripheral alternate functions
  input  wire             timer_zero_output,
  input  wire             timer_one_output,
  input  wire             timer_two_output,
  output wire             event_counter_input,
  output wire             external_irq_one,
  output wire             external_irq_two
);

  reg  [WIDTH-1:0] first_data_reg;
  reg  [WIDTH-1:0] second_data_reg;
  reg  [WIDTH-1:0] first_dir_reg;
  reg  [WIDTH-1:0] second_dir_reg;
  reg  [WIDTH-1:0] first_od_reg;
  reg  [WIDTH-1:0] second_od_reg;
  reg  [WIDTH-1:0] first_pu_reg;
  reg  [WIDTH-1:0] second_pu_reg;
  reg  [WIDTH-1:0] func_sel_reg;
  reg  [7:0]       rdata_next;
  reg              hit_next;
  wire [WIDTH-1:0] first_level;
  wire [WIDTH-1:0] second_level;

  wire wr_first_data  = reg_wr && (reg_addr == `ADDR_FIRST_PORT_DATA);
  wire wr_second_data = reg_wr && (reg_addr == `ADDR_SECOND_PORT_DATA);

  // Control registers; whole-byte writes only, software must not RMW
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_dir_reg  <= `RESET_DIRECTION;
      second_dir_reg <= `RESET_DIRECTION;
      first_od_reg   <= `RESET_OPEN_DRAIN;
      second_od_reg  <= `RESET_OPEN_DRAIN;
      first_pu_reg   <= `RESET_PULLUP;
      second_pu_reg  <= `RESET_PULLUP;
      func_sel_reg   <= `RESET_FUNC_SEL;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_FIRST_PORT_DIRECTION:   first_dir_reg  <= reg_wdata;
        `ADDR_SECOND_PORT_DIRECTION:  second_dir_reg <= reg_wdata;
        `ADDR_FIRST_PORT_OPEN_DRAIN:  first_od_reg   <= reg_wdata;
        `ADDR_SECOND_PORT_OPEN_DRAIN: second_od_reg  <= reg_wdata;
        `ADDR_FIRST_PORT_PULLUP:      first_pu_reg   <= reg_wdata;
        `ADDR_SECOND_PORT_PULLUP:     second_pu_reg  <= reg_wdata;
        `ADDR_SECOND_PORT_FUNC_SEL:   func_sel_reg   <= reg_wdata;
        default:                      first_dir_reg  <= first_dir_reg;
      endcase
    end
  end

  // Data registers carry no reset; pins are inputs until software writes the direction registers
  always @(posedge clk)
  begin
    if (wr_first_data)
      first_data_reg <= reg_wdata;
    if (wr_second_data)
      second_data_reg <= reg_wdata;
  end

  // Read path: data registers mix latch and pin per direction
  always @*
  begin
    rdata_next = 8'h00;
    hit_next   = 1'b1;
    case (reg_addr)
      `ADDR_FIRST_PORT_DATA:
        rdata_next = (first_data_reg & first_dir_reg) | (first_level & ~first_dir_reg);
      `ADDR_SECOND_PORT_DATA:
        rdata_next = (second_data_reg & second_dir_reg) |
                     (second_level & ~second_dir_reg);
      `ADDR_FIRST_PORT_DIRECTION,
      `ADDR_SECOND_PORT_DIRECTION,
      `ADDR_FIRST_PORT_OPEN_DRAIN,
      `ADDR_SECOND_PORT_OPEN_DRAIN,
      `ADDR_FIRST_PORT_PULLUP,
      `ADDR_SECOND_PORT_PULLUP,
      `ADDR_SECOND_PORT_FUNC_SEL:
        rdata_next = 8'h00;
      default:
        hit_next = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
      reg_hit   <= reg_rd & hit_next;
    end
  end

  // Second port: function bits override direction and data
  reg [WIDTH-1:0] sec_drive_en;
  reg [WIDTH-1:0] sec_drive_val;
  always @*
  begin
    sec_drive_en  = second_dir_reg & ~func_sel_reg;
    sec_drive_val = second_data_reg;
    if (func_sel_reg[`BIT_TIMER_ZERO])
    begin
      sec_drive_en[`BIT_TIMER_ZERO]  = 1'b1;
      sec_drive_val[`BIT_TIMER_ZERO] = timer_zero_output;
    end
    if (func_sel_reg[`BIT_TIMER_ONE])
    begin
      sec_drive_en[`BIT_TIMER_ONE]  = 1'b1;
      sec_drive_val[`BIT_TIMER_ONE] = timer_one_output;
    end
    if (func_sel_reg[`BIT_TIMER_TWO])
    begin
      sec_drive_en[`BIT_TIMER_TWO]  = 1'b1;
      sec_drive_val[`BIT_TIMER_TWO] = timer_two_output;
    end
  end

  // Input functions read low when not selected, so peripherals see idle
  assign event_counter_input =
    func_sel_reg[`BIT_EVENT_COUNTER] & second_level[`BIT_EVENT_COUNTER];
  assign external_irq_two = func_sel_reg[`BIT_IRQ_TWO] & second_level[`BIT_IRQ_TWO];
  assign external_irq_one = func_sel_reg[`BIT_IRQ_ONE] & second_level[`BIT_IRQ_ONE];

  port_pin_cell #(
    .WIDTH (WIDTH)
  ) u_first (
    .clk           (clk),
    .rst_n         (rst_n),
    .drive_en      (first_dir_reg),
    .drive_val     (first_data_reg),
    .open_drain    (first_od_reg),
    .pullup_off    (first_pu_reg),
    .pin_in        (first_pin_in),
    .pin_out       (first_pin_out),
    .pin_oe        (first_pin_oe),
    .pin_pullup_en (first_pin_pullup_en),
    .pin_level     (first_level)
  );

  port_pin_cell #(
    .WIDTH (WIDTH)
  ) u_second (
    .clk           (clk),
    .rst_n         (rst_n),
    .drive_en      (sec_drive_en),
    .drive_val     (sec_drive_val),
    .open_drain    (second_od_reg),
    .pullup_off    (second_pu_reg),
    .pin_in        (second_pin_in),
    .pin_out       (second_pin_out),
    .pin_oe        (second_pin_oe),
    .pin_pullup_en (second_pin_pullup_en),
    .pin_level     (second_level)
  );

endmodule

`default_nettype wire

/* File: rtl/dual_port_bidir_io_regs.vh */
// Register addresses, reset values and pin-function bit positions of the
// dual bidirectional port block. Included by the design files only.
`ifndef DUAL_PORT_BIDIR_IO_REGS_VH
`define DUAL_PORT_BIDIR_IO_REGS_VH

`define ADDR_FIRST_PORT_DATA        8'hC0
`define ADDR_FIRST_PORT_DIRECTION   8'hC1
`define ADDR_SECOND_PORT_DATA       8'hC2
`define ADDR_SECOND_PORT_DIRECTION  8'hC3
`define ADDR_SECOND_PORT_FUNC_SEL   8'hC9
`define ADDR_SECOND_PORT_OPEN_DRAIN 8'hDE
`define ADDR_FIRST_PORT_OPEN_DRAIN  8'hE4
`define ADDR_FIRST_PORT_PULLUP      8'hF8
`define ADDR_SECOND_PORT_PULLUP     8'hF9

`define RESET_DIRECTION   8'h00
`define RESET_OPEN_DRAIN  8'h00
`define RESET_PULLUP      8'h00
`define RESET_FUNC_SEL    8'h00

`define BIT_TIMER_ZERO    7
`define BIT_TIMER_ONE     6
`define BIT_TIMER_TWO     5
`define BIT_EVENT_COUNTER 4
`define BIT_IRQ_TWO       2
`define BIT_IRQ_ONE       1

`endif

/* File: rtl/port_pin_cell.v */
// One 8-bit port's pin drivers: direction, open drain, pull-up, input sync.
// Assumes an asynchronous pin input and a shared clock with the register file.
`timescale 1ns/1ns
`default_nettype none

module port_pin_cell #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Effective control per pin
  input  wire [WIDTH-1:0] drive_en,
  input  wire [WIDTH-1:0] drive_val,
  input  wire [WIDTH-1:0] open_drain,
  input  wire [WIDTH-1:0] pullup_off,
  // Pin signals
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe,
  output wire [WIDTH-1:0] pin_pullup_en,
  // Synchronised level
  output wire [WIDTH-1:0] pin_level
);

  reg [WIDTH-1:0] sync_a_reg;
  reg [WIDTH-1:0] sync_b_reg;

  // Two stages keep metastability out of the read path
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a_reg <= {WIDTH{1'b0}};
      sync_b_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      sync_a_reg <= pin_in;
      sync_b_reg <= sync_a_reg;
    end
  end
  assign pin_level = sync_b_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      // Open drain only pulls low; a high bit releases the pin
      assign pin_oe[i]  = drive_en[i] & ~(open_drain[i] & drive_val[i]);
      assign pin_out[i] = drive_val[i];
      assign pin_pullup_en[i] = ~drive_en[i] & ~pullup_off[i];
    end
  endgenerate

endmodule

`default_nettype wire

/* File: bench/dual_port_bidir_io_properties.sv */
// Port checks for the dual port block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module dual_port_bidir_io_checker #(
  parameter WIDTH = 8
) (
  // Clock, reset, register port
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_rd,
  input wire logic             reg_wr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic             reg_hit,
  // Pins
  input wire logic [WIDTH-1:0] first_pin_oe,
  input wire logic [WIDTH-1:0] first_pin_pullup_en,
  input wire logic [WIDTH-1:0] second_pin_oe,
  input wire logic [WIDTH-1:0] second_pin_in,
  input wire logic             external_irq_one,
  input wire logic             event_counter_input
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rst_dir_a: assert property ($rose(rst_n) |-> (first_pin_oe | second_pin_oe) == 8'h00)
    else $error("pin driven after reset");
  rst_pull_a: assert property ($rose(rst_n) |-> first_pin_pullup_en == 8'hFF)
    else $error("pull-ups off after reset");
  dir_write_a: assert property (reg_wr && reg_addr == 8'hC1 |=>
    (first_pin_oe & ~$past(reg_wdata)) == 8'h00)
    else $error("input pin driven");
  wo_read_a: assert property (reg_rd && reg_addr inside {8'hC1, 8'hC3, 8'hC9, 8'hE4, 8'hF8}
    |=> reg_rdata == 8'h00 && reg_hit)
    else $error("write-only register readable");
  unmap_read_a: assert property (reg_rd && reg_addr == 8'hC6 |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  idle_read_a: assert property (!reg_rd |=> !reg_hit && reg_rdata == 8'h00)
    else $error("read data without read");
  pull_out_a: assert property ((first_pin_oe & first_pin_pullup_en) == 8'h00)
    else $error("pull-up on driven pin");
  irq_sync_a: assert property (external_irq_one |-> $past(second_pin_in[1], 2))
    else $error("irq one not from pin");
  event_sync_a: assert property (event_counter_input |-> $past(second_pin_in[4], 2))
    else $error("event input not from pin");
endmodule
bind dual_port_bidir_io dual_port_bidir_io_checker #(.WIDTH(WIDTH)) chk (.clk, .rst_n,
  .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit, .first_pin_oe,
  .first_pin_pullup_en, .second_pin_oe, .second_pin_in, .external_irq_one,
  .event_counter_input);
`default_nettype wire

/* File: bench/pin_partner.sv */
// Board side of one port: pin level from chip and outside drive.
// Undriven pins without pull-up float, shown as a changing pattern.
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  // Clock
  input wire logic        clk,
  // Chip side
  input wire logic [7:0]  out,
  input wire logic [7:0]  oe,
  input wire logic [7:0]  pu,
  // Outside drive
  input wire logic [7:0]  ext,
  input wire logic [7:0]  ext_en,
  output logic [7:0]      lvl
);
  logic [7:0] flt = 8'h55;
  always @(posedge clk) flt <= ~flt;
  assign lvl = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | flt));
endmodule
`default_nettype wire

/* File: bench/tb_dual_port_bidir_io.sv */
// Register-call tests of the dual port block.
// Pins resolved by two partner models.
`timescale 1ns/1ns
`default_nettype none
module tb_dual_port_bidir_io;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ext0 = 8'h00, ext1 = 8'h00, ext_en = 8'h00;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, reg_hit, ec, irq1, irq2;
  logic [2:0] tmr = 3'b000;
  logic [7:0] reg_rdata, p0_in, p0_out, p0_oe, p0_pu, p1_in, p1_out, p1_oe, p1_pu;
  int         failures = 0, cmp_count = 0;
  always #5 clk = ~clk;
  dual_port_bidir_io dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .first_pin_in(p0_in), .first_pin_out(p0_out), .first_pin_oe(p0_oe),
    .first_pin_pullup_en(p0_pu), .second_pin_in(p1_in), .second_pin_out(p1_out),
    .second_pin_oe(p1_oe), .second_pin_pullup_en(p1_pu), .timer_zero_output(tmr[2]),
    .timer_one_output(tmr[1]), .timer_two_output(tmr[0]), .event_counter_input(ec),
    .external_irq_one(irq1), .external_irq_two(irq2));
  pin_partner pp0 (.clk(clk), .out(p0_out), .oe(p0_oe), .pu(p0_pu), .ext(ext0),
    .ext_en(ext_en), .lvl(p0_in));
  pin_partner pp1 (.clk(clk), .out(p1_out), .oe(p1_oe), .pu(p1_pu), .ext(ext1),
    .ext_en(ext_en), .lvl(p1_in));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Whole-byte writes only; no bit updates exist
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
    chk("hit", {7'h00, h}, {7'h00, reg_hit});
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk("p0_oe", 8'h00, p0_oe);
    chk("p1_oe", 8'h00, p1_oe);
    chk("p0_pu", 8'hFF, p0_pu);
    chk("p1_pu", 8'hFF, p1_pu);
    $display("test reset done");
    wr(8'hC1, 8'hFF);
    wr(8'hE4, 8'h0F);
    wr(8'hC0, 8'hA5);
    settle(1);
    chk("p0_oe", 8'hFA, p0_oe);
    chk("p0_out", 8'hA0, p0_out & p0_oe);
    chk("p0_pu", 8'h00, p0_pu);
    $display("test output done");
    ext0 <= 8'h3C;
    ext1 <= 8'h16;
    ext_en <= 8'hFF;
    tmr <= 3'b101;
    wr(8'hC1, 8'h0F);
    wr(8'hF8, 8'h30);
    settle(3);
    chk("p0_pu", 8'hC0, p0_pu);
    rd(8'hC0, 8'h35, 1'b1);
    rd(8'hC1, 8'h00, 1'b1);
    rd(8'hE4, 8'h00, 1'b1);
    rd(8'hF8, 8'h00, 1'b1);
    rd(8'hC6, 8'h00, 1'b0);
    $display("test input done");
    wr(8'hC3, 8'hFF);
    wr(8'hC2, 8'hF0);
    wr(8'hC9, 8'hF6);
    settle(3);
    chk("p1_oe", 8'hE9, p1_oe);
    chk("p1_out", 8'hA0, p1_out & p1_oe);
    chk("ec", 8'h01, {7'h00, ec});
    chk("irq1", 8'h01, {7'h00, irq1});
    chk("irq2", 8'h01, {7'h00, irq2});
    rd(8'hC9, 8'h00, 1'b1);
    wr(8'hC9, 8'h00);
    settle(1);
    chk("p1_oe", 8'hFF, p1_oe);
    chk("p1_pu", 8'h00, p1_pu);
    chk("ec", 8'h00, {7'h00, ec});
    $display("test function done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
